// ### shared/smsp_defines.svh
// Timing counts, widths and fixed values for the serial port host controller
`ifndef SMSP_DEFINES_SVH
`define SMSP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define SMSP_CLK_PERIOD_NS      5
// Device CPU clock period; plain default (8 MHz), set to the real part's rate
`define SMSP_DEV_CPU_PERIOD_NS  125
// Shortest legal serial clock period seen by a slave device: two device CPU clocks
`define SMSP_SCK_MIN_PERIOD_NS  (2 * `SMSP_DEV_CPU_PERIOD_NS)
// Least half period in own clocks, rounded up
`define SMSP_SCK_MIN_HALF_CYC   ((`SMSP_SCK_MIN_PERIOD_NS + 2 * `SMSP_CLK_PERIOD_NS - 1) / (2 * `SMSP_CLK_PERIOD_NS))
// Least time select stays high between bytes
`define SMSP_SS_GAP_NS          250
`define SMSP_SS_GAP_CYC         ((`SMSP_SS_GAP_NS + `SMSP_CLK_PERIOD_NS - 1) / `SMSP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Widths and values
// ----------------------------------------------------------------------------
`define SMSP_DATA_W             8
`define SMSP_FIFO_DEPTH         16
`define SMSP_DIV_W              9
`define SMSP_FILL_BYTE          8'hFF
`define SMSP_SCK_EDGES          4'hF

`endif

// ### shared/smsp_pkg.sv
// Types shared by the serial port host controller
package smsp_pkg;

  // --------------------------------------------------------------------------
  // Master sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SMSP_ST_IDLE  = 3'b000,
    SMSP_ST_LEAD  = 3'b001,
    SMSP_ST_SHIFT = 3'b010,
    SMSP_ST_TRAIL = 3'b011,
    SMSP_ST_GAP   = 3'b100
  } smsp_state_e;

endpackage : smsp_pkg

// ### src/smsp_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module smsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------------
  assign in_ready  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid = (count_ff != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_ready && out_valid;
  assign out_data  = mem_ff[rd_ptr_ff];

  // Storage is not reset; only the pointers define content
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      case ({push, pop})
        2'b10:   count_ff <= count_ff + 1'b1;
        2'b01:   count_ff <= count_ff - 1'b1;
        default: count_ff <= count_ff;
      endcase
    end
  end

endmodule : smsp_fifo

`default_nettype wire

// ### src/smsp_host.sv
// Host controller that exchanges bytes with the serial port device as master or slave
`timescale 1ns/100ps
`default_nettype none
`include "smsp_defines.svh"

module smsp_host
  import smsp_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    cfg_role_slave,
  input  wire logic                    cfg_cpol,
  input  wire logic                    cfg_cpha,
  input  wire logic [7:0]              cfg_div_extra,
  input  wire logic                    cfg_simplex,
  input  wire logic                    cfg_simplex_tx,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  input  wire logic [`SMSP_DATA_W-1:0] tx_data,
  output logic                         rx_valid,
  output logic [`SMSP_DATA_W-1:0]      rx_data,
  output logic                         busy,
  output logic                         sck_o,
  output logic                         sck_oe,
  input  wire logic                    sck_i,
  output logic                         mosi_o,
  output logic                         mosi_oe,
  input  wire logic                    mosi_i,
  input  wire logic                    miso_i,
  output logic                         miso_o,
  output logic                         miso_oe,
  output logic                         ss_n_o
);

  smsp_state_e                 state_ff;
  smsp_state_e                 nxt_state;
  logic                        role_slave_ff;
  logic                        cpol_ff;
  logic                        cpha_ff;
  logic                        simplex_ff;
  logic                        simplex_tx_ff;
  logic [`SMSP_DIV_W-1:0]      div_cnt_ff;
  logic [`SMSP_DIV_W-1:0]      div_limit;
  logic                        tick;
  logic [3:0]                  edge_cnt_ff;
  logic                        sck_ff;
  logic                        ss_n_ff;
  logic [`SMSP_DATA_W-1:0]     tx_sr_ff;
  logic [`SMSP_DATA_W-1:0]     rx_sr_ff;
  logic [2:0]                  samp_cnt_ff;
  logic                        dout_ff;
  logic                        rx_valid_ff;
  logic [`SMSP_DATA_W-1:0]     rx_data_ff;
  logic                        slv_armed_ff;
  logic [2:0]                  sck_sync_ff;
  logic [1:0]                  mosi_sync_ff;
  logic [1:0]                  miso_sync_ff;
  logic                        lead_ev;
  logic                        trail_ev;
  logic                        samp_ev;
  logic                        shift_ev;
  logic                        load_ev;
  logic                        byte_done;
  logic                        din;
  logic                        fifo_valid;
  logic [`SMSP_DATA_W-1:0]     fifo_data;
  logic [`SMSP_DATA_W-1:0]     load_byte;
  logic                        m_start;
  logic                        m_chain;
  logic                        s_lead;
  logic                        s_trail;

  // Converts a byte into the shifter image for the chosen phase
  function automatic logic [`SMSP_DATA_W-1:0] shifter_image(input logic [`SMSP_DATA_W-1:0] b,
                                                            input logic                    pha);
    shifter_image = pha ? b : {b[`SMSP_DATA_W-2:0], 1'b0};
  endfunction : shifter_image

  // ----------------------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------------------
  smsp_fifo #(
    .W     (`SMSP_DATA_W),
    .DEPTH (`SMSP_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (load_ev),
    .out_data  (fifo_data)
  );

  // An empty FIFO in slave role still answers, with a fill byte
  assign load_byte = fifo_valid ? fifo_data : `SMSP_FILL_BYTE;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // Two stages before use; third sck stage only serves the edge finder
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_sync_ff  <= 3'h0;
      mosi_sync_ff <= 2'h0;
      miso_sync_ff <= 2'h0;
    end else begin
      sck_sync_ff  <= {sck_sync_ff[1:0], sck_i};
      mosi_sync_ff <= {mosi_sync_ff[0], mosi_i};
      miso_sync_ff <= {miso_sync_ff[0], miso_i};
    end
  end

  // Device-as-master clock edges; leading edge leaves the idle level
  assign s_lead  = role_slave_ff && (sck_sync_ff[1] != sck_sync_ff[2]) && (sck_sync_ff[2] == cpol_ff);
  assign s_trail = role_slave_ff && (sck_sync_ff[1] != sck_sync_ff[2]) && (sck_sync_ff[2] != cpol_ff);

  // ----------------------------------------------------------------------------
  // Configuration latch
  // ----------------------------------------------------------------------------
  // Settings only move between bytes so both ends agree for a whole byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      role_slave_ff <= 1'b0;
      cpol_ff       <= 1'b0;
      cpha_ff       <= 1'b0;
      simplex_ff    <= 1'b0;
      simplex_tx_ff <= 1'b0;
    end else if (state_ff == SMSP_ST_IDLE && samp_cnt_ff == 3'h0) begin
      role_slave_ff <= cfg_role_slave;
      cpol_ff       <= cfg_cpol;
      cpha_ff       <= cfg_cpha;
      simplex_ff    <= cfg_simplex;
      simplex_tx_ff <= cfg_simplex_tx;
    end
  end

  // ----------------------------------------------------------------------------
  // Master half-period divider
  // ----------------------------------------------------------------------------
  // Never faster than half the device CPU clock, extra slows it further
  assign div_limit = (state_ff == SMSP_ST_GAP) ?
                     `SMSP_DIV_W'(`SMSP_SS_GAP_CYC - 1) :
                     `SMSP_DIV_W'(`SMSP_SCK_MIN_HALF_CYC - 1) + `SMSP_DIV_W'(cfg_div_extra);
  assign tick      = (state_ff != SMSP_ST_IDLE) && (div_cnt_ff == div_limit);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt_ff <= '0;
    end else if (state_ff == SMSP_ST_IDLE || tick) begin
      div_cnt_ff <= '0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Master sequencer
  // ----------------------------------------------------------------------------
  // Only this end starts a byte when it is master, and only with data queued
  assign m_start = (state_ff == SMSP_ST_IDLE) && !role_slave_ff && !cfg_role_slave && fifo_valid;
  // Second-edge capture keeps select low across queued bytes
  assign m_chain = (state_ff == SMSP_ST_TRAIL) && tick && cpha_ff && fifo_valid;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SMSP_ST_IDLE: begin
        if (m_start) begin
          nxt_state = SMSP_ST_LEAD;
        end
      end
      SMSP_ST_LEAD: begin
        if (tick) begin
          nxt_state = SMSP_ST_SHIFT;
        end
      end
      SMSP_ST_SHIFT: begin
        if (tick && edge_cnt_ff == `SMSP_SCK_EDGES) begin
          nxt_state = SMSP_ST_TRAIL;
        end
      end
      SMSP_ST_TRAIL: begin
        if (m_chain) begin
          nxt_state = SMSP_ST_LEAD;
        end else if (tick) begin
          nxt_state = SMSP_ST_GAP;
        end
      end
      SMSP_ST_GAP: begin
        if (tick) begin
          nxt_state = SMSP_ST_IDLE;
        end
      end
      default: nxt_state = SMSP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= SMSP_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Edge counter: sixteen edges make eight clock periods
  always_ff @(posedge clk) begin
    if (!nrst) begin
      edge_cnt_ff <= 4'h0;
    end else if (state_ff != SMSP_ST_SHIFT) begin
      edge_cnt_ff <= 4'h0;
    end else if (tick) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
    end
  end

  // Serial clock rests at the polarity level outside the shift phase
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sck_ff <= 1'b0;
    end else if (state_ff == SMSP_ST_IDLE) begin
      sck_ff <= cfg_cpol;
    end else if (state_ff == SMSP_ST_SHIFT && tick) begin
      sck_ff <= ~sck_ff;
    end
  end

  // Select: low over a byte, high between first-edge capture bytes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ss_n_ff <= 1'b1;
    end else if (role_slave_ff) begin
      ss_n_ff <= 1'b1;
    end else if (m_start) begin
      ss_n_ff <= 1'b0;
    end else if (state_ff == SMSP_ST_TRAIL && tick && !m_chain) begin
      ss_n_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // Shared shift events for both roles
  // ----------------------------------------------------------------------------
  assign lead_ev  = s_lead || (state_ff == SMSP_ST_SHIFT && tick && !edge_cnt_ff[0]);
  assign trail_ev = s_trail || (state_ff == SMSP_ST_SHIFT && tick && edge_cnt_ff[0]);
  // Capture on first edge for phase 0, second edge for phase 1
  assign samp_ev  = cpha_ff ? trail_ev : lead_ev;
  // Phase 0 must not shift on the closing edge of a finished byte
  assign shift_ev = cpha_ff ? lead_ev : (trail_ev && samp_cnt_ff != 3'h0);
  assign byte_done = samp_ev && samp_cnt_ff == 3'h7;
  // Slave role loads its answer on entry, before any device clock, then after each byte
  assign load_ev  = m_start || m_chain ||
                    (role_slave_ff && (!slv_armed_ff || byte_done));
  // Single shared line, master role only: receive on mosi, the line it would drive; slave role always receives on mosi
  assign din      = role_slave_ff ? mosi_sync_ff[1] :
                    (simplex_ff ? mosi_sync_ff[1] : miso_sync_ff[1]);

  // Slave preload happens once on entering the role, then after each byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slv_armed_ff <= 1'b0;
    end else begin
      slv_armed_ff <= role_slave_ff;
    end
  end

  // Transmit shifter, most significant bit first
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_sr_ff <= '0;
      dout_ff  <= 1'b0;
    end else if (load_ev) begin
      tx_sr_ff <= shifter_image(load_byte, cpha_ff);
      if (!cpha_ff) begin
        dout_ff <= load_byte[`SMSP_DATA_W-1];
      end
    end else if (shift_ev) begin
      dout_ff  <= tx_sr_ff[`SMSP_DATA_W-1];
      tx_sr_ff <= {tx_sr_ff[`SMSP_DATA_W-2:0], 1'b0};
    end
  end

  // Receive shifter and bit count
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_sr_ff    <= '0;
      samp_cnt_ff <= 3'h0;
    end else if (!role_slave_ff && state_ff == SMSP_ST_IDLE) begin
      samp_cnt_ff <= 3'h0;
    end else if (samp_ev) begin
      rx_sr_ff    <= {rx_sr_ff[`SMSP_DATA_W-2:0], din};
      samp_cnt_ff <= samp_cnt_ff + 3'h1;
    end
  end

  // Finished bytes land in a buffer register, apart from the shifter
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_valid_ff <= 1'b0;
      rx_data_ff  <= '0;
    end else begin
      rx_valid_ff <= byte_done && !(simplex_ff && simplex_tx_ff);
      if (byte_done) begin
        rx_data_ff <= {rx_sr_ff[`SMSP_DATA_W-2:0], din};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign rx_valid = rx_valid_ff;
  assign rx_data  = rx_data_ff;
  assign busy     = (state_ff != SMSP_ST_IDLE) || (samp_cnt_ff != 3'h0);
  assign sck_o    = sck_ff;
  assign sck_oe   = !role_slave_ff;
  assign mosi_o   = dout_ff;
  // Shared line in receive direction: release it so the device may drive
  assign mosi_oe  = !role_slave_ff && !(simplex_ff && !simplex_tx_ff);
  assign miso_o   = dout_ff;
  assign miso_oe  = role_slave_ff && !(simplex_ff && !simplex_tx_ff);
  assign ss_n_o   = ss_n_ff;

endmodule : smsp_host

`default_nettype wire

// ### test/smsp_dev_model.sv
// Behavioural serial port device: slave to the host, or master on command
`timescale 1ns/100ps
`default_nettype none

module smsp_dev_model (
  input  wire logic dev_master,
  input  wire logic cpol,
  input  wire logic cpha,
  input  wire logic sck_i,
  input  wire logic ss_n,
  input  wire logic mosi_i,
  input  wire logic miso_i,
  output logic      sck_o,
  output logic      mosi_o,
  output logic      miso_o
);
  logic [7:0] tx_byte = 8'hFF; // Byte returned in every frame
  logic [7:0] tx_sr;
  logic [7:0] rx_sr;
  logic [7:0] dev_rxq[$];      // Received bytes, oldest first
  logic       sck_r   = 1'b0;
  logic       in_xfer = 1'b0;
  int         edges   = 0;

  // Clock stands at the polarity level outside frames
  assign sck_o = in_xfer ? sck_r : cpol;

  initial begin
    mosi_o = 1'b0;
    miso_o = 1'b0;
  end

  // Selection loads the shifter; first-edge capture shows bit 7 at once
  always @(negedge ss_n) begin
    if (!dev_master) begin
      tx_sr  = tx_byte;
      edges  = 0;
      miso_o = cpha ? ~miso_o : tx_byte[7];
    end
  end

  // A released line must not keep its last level
  always @(posedge ss_n) miso_o = ~miso_o;

  // Capture on one edge, shift on the other; sixteen edges close a byte
  always @(sck_i) begin
    if (!dev_master && !ss_n) begin
      edges++;
      if ((sck_i != cpol) != cpha) rx_sr = {rx_sr[6:0], mosi_i};
      else if (cpha) begin
        miso_o = tx_sr[7];
        tx_sr  = tx_sr << 1;
      end else begin
        tx_sr  = tx_sr << 1;
        miso_o = tx_sr[7];
      end
      if (edges == 16) begin
        dev_rxq.push_back(rx_sr);
        edges = 0;
        tx_sr = tx_byte;
      end
    end
  end

  // Device as master: one byte at a 125 ns clock, phase unrelated to the host clock
  task automatic xfer(input logic [7:0] b);
    int k;
    #31.3;
    tx_sr   = b;
    mosi_o  = cpha ? ~mosi_o : b[7];
    in_xfer = 1'b1;
    sck_r   = cpol;
    for (k = 0; k < 8; k++) begin
      #62.5 sck_r = ~cpol;
      if (cpha) begin
        mosi_o = tx_sr[7];
        tx_sr  = tx_sr << 1;
      end else rx_sr = {rx_sr[6:0], miso_i};
      #62.5 sck_r = cpol;
      if (cpha) rx_sr = {rx_sr[6:0], miso_i};
      else begin
        tx_sr  = tx_sr << 1;
        mosi_o = tx_sr[7];
      end
    end
    in_xfer = 1'b0;
    dev_rxq.push_back(rx_sr);
  endtask : xfer

endmodule : smsp_dev_model

`default_nettype wire

// ### test/smsp_host_chk.sv
// Pin-level assertions for the serial port host controller
`timescale 1ns/100ps
`default_nettype none

module smsp_host_chk (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       cfg_cpol,
  input wire logic       cfg_cpha,
  input wire logic [7:0] cfg_div_extra,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic       busy,
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       ss_n_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [8:0] gap_ff;   // Cycles since the clock pin last moved
  logic [8:0] hi_ff;    // Cycles with select high, saturating
  logic [3:0] edge_ff;  // Clock edges in the current byte, modulo sixteen
  logic       sck_q_ff;

  // ---------------------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------------------
  // Select count starts saturated so a byte right after reset is legal
  always_ff @(posedge clk) begin
    sck_q_ff <= sck_o;
    if (!nrst) begin
      gap_ff  <= 9'h000;
      hi_ff   <= 9'h1FF;
      edge_ff <= 4'h0;
    end else begin
      gap_ff  <= (sck_o != sck_q_ff) ? 9'h001 : ((gap_ff == 9'h1FF) ? gap_ff : gap_ff + 9'h001);
      hi_ff   <= !ss_n_o ? 9'h000 : ((hi_ff == 9'h1FF) ? hi_ff : hi_ff + 9'h001);
      edge_ff <= ss_n_o ? 4'h0 : edge_ff + {3'h0, sck_o != sck_q_ff};
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_edge_spacing: assert property ($changed(sck_o) && !ss_n_o && edge_ff != 4'h0
    |-> gap_ff == 9'h019 + {1'b0, cfg_div_extra}) else $error("clock edge spacing wrong");
  a_byte_edges: assert property ($rose(ss_n_o) |-> edge_ff == 4'h0)
    else $error("clock edges per byte not sixteen");
  a_idle_level: assert property (ss_n_o && !busy && sck_oe && $stable(cfg_cpol) && $past(nrst)
    |-> sck_o == cfg_cpol) else $error("idle clock not at polarity");
  a_lead_still: assert property ($fell(ss_n_o) |-> $stable(sck_o)[*8])
    else $error("clock moved at select fall");
  a_select_gap: assert property ($fell(ss_n_o) && !cfg_cpha |-> hi_ff >= 9'h032)
    else $error("select gap too short");
  a_slave_quiet: assert property (!sck_oe |-> ss_n_o && !mosi_oe)
    else $error("select or data driven in slave role");
  a_master_miso: assert property (sck_oe |-> !miso_oe)
    else $error("slave output driven in master role");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("receive pulse too long");
  a_rx_in_frame: assert property (rx_valid && sck_oe |-> !ss_n_o)
    else $error("receive outside a frame");
  a_frame_busy: assert property (!ss_n_o |-> busy)
    else $error("not busy while selected");
  a_reset_state: assert property ($rose(nrst) |-> ss_n_o && tx_ready && !rx_valid && !busy)
    else $error("bad state after reset");

endmodule : smsp_host_chk

bind smsp_host smsp_host_chk smsp_host_chk_i (.clk, .nrst, .cfg_cpol, .cfg_cpha, .cfg_div_extra, .tx_ready,
  .rx_valid, .busy, .sck_o, .sck_oe, .mosi_oe, .miso_oe, .ss_n_o);

`default_nettype wire

// ### test/smsp_host_tb_top.sv
// Self-checking bench for the serial port host controller with a device model
`timescale 1ns/100ps
`default_nettype none
`include "smsp_defines.svh"

module smsp_host_tb_top;
  logic       clk = 1'b0;
  logic       nrst, cfg_role_slave, cfg_cpol, cfg_cpha, tx_valid, dev_master;
  logic       cfg_simplex, cfg_simplex_tx;
  logic [7:0] cfg_div_extra, tx_data, rx_data;
  logic       tx_ready, rx_valid, busy, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o;
  logic       dev_sck, dev_mosi, dev_miso;
  logic [7:0] rxq[$];
  int         errors  = 0;
  int         n_tests = 0;
  int         i;

  // Resolve each shared line from whichever side drives it
  wire logic sck_w  = sck_oe ? sck_o : dev_sck;
  // On one shared data line the device's tied pins carry its slave output
  wire logic mosi_w = mosi_oe ? mosi_o : (cfg_simplex ? dev_miso : dev_mosi);
  wire logic miso_w = miso_oe ? miso_o : dev_miso;

  smsp_host smsp_host_i (.clk, .nrst, .cfg_role_slave, .cfg_cpol, .cfg_cpha, .cfg_div_extra,
    .cfg_simplex, .cfg_simplex_tx, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data, .busy,
    .sck_o, .sck_oe, .sck_i(sck_w), .mosi_o, .mosi_oe, .mosi_i(mosi_w), .miso_i(miso_w), .miso_o, .miso_oe,
    .ss_n_o);

  smsp_dev_model smsp_dev_model_i (.dev_master, .cpol(cfg_cpol), .cpha(cfg_cpha), .sck_i(sck_w),
    .ss_n(ss_n_o), .mosi_i(mosi_w), .miso_i(miso_w), .sck_o(dev_sck), .mosi_o(dev_mosi), .miso_o(dev_miso));

  always #2.5 clk = ~clk;

  // Collect every received byte; the pulse lasts one cycle, so look mid-cycle
  always @(negedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // Push one byte, holding it until the queue accepts it
  task automatic push(input logic [7:0] b);
    int k;
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data  = b;
    for (k = 0; tx_ready !== 1'b1; k++) begin
      if (k == 40000) begin
        errors++;
        finish_test();
      end
      @(negedge clk);
    end
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : push

  // Wait for n received bytes and the link back at rest
  task automatic wait_done(input int n);
    int k;
    for (k = 0; !(rxq.size() >= n && busy === 1'b0 && ss_n_o === 1'b1); k++) begin
      if (k == 40000) begin
        errors++;
        finish_test();
      end
      @(negedge clk);
    end
  endtask : wait_done

  initial begin
    nrst           = 1'b0;
    cfg_role_slave = 1'b0;
    cfg_cpol       = 1'b0;
    cfg_cpha       = 1'b0;
    cfg_div_extra  = 8'h00;
    tx_valid       = 1'b0;
    tx_data        = 8'h00;
    dev_master     = 1'b0;
    cfg_simplex    = 1'b0;
    cfg_simplex_tx = 1'b0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    check({3'h0, ss_n_o, tx_ready, busy, rx_valid, sck_oe}, 8'h19);
    // Single bytes in all four clock modes, each with its own divider stretch
    for (i = 0; i < 4; i++) begin
      cfg_cpol                 = i[1];
      cfg_cpha                 = i[0];
      cfg_div_extra            = 8'(i * 3);
      smsp_dev_model_i.tx_byte = 8'hA5 ^ 8'(i);
      push(8'h3C + 8'(i));
      wait_done(1);
      check(rxq.pop_front(), 8'hA5 ^ 8'(i));
      check(smsp_dev_model_i.dev_rxq.pop_front(), 8'h3C + 8'(i));
    end
    // Fill the queue until it refuses, select held across bytes and then not
    cfg_div_extra            = 8'h00;
    cfg_cpol                 = 1'b0;
    smsp_dev_model_i.tx_byte = 8'h5A;
    for (int c = 1; c >= 0; c--) begin
      cfg_cpha = c[0];
      for (i = 0; i < `SMSP_FIFO_DEPTH + 2; i++) begin
        push(8'(i * 17));
        if (i == `SMSP_FIFO_DEPTH) check({7'h0, tx_ready}, 8'h00);
      end
      wait_done(`SMSP_FIFO_DEPTH + 2);
      for (i = 0; i < `SMSP_FIFO_DEPTH + 2; i++) begin
        check(rxq.pop_front(), 8'h5A);
        check(smsp_dev_model_i.dev_rxq.pop_front(), 8'(i * 17));
      end
    end
    // One shared data line: host receives, then sends with no receive pulse
    cfg_simplex              = 1'b1;
    smsp_dev_model_i.tx_byte = 8'hC3;
    for (i = 0; i < 2; i++) begin
      cfg_simplex_tx = i[0];
      push(8'h69);
      repeat (3) @(negedge clk);
      wait_done(1 - i);
      check(8'(rxq.size()), 8'(1 - i));
      if (i == 0) check(rxq.pop_front(), 8'hC3);
      check(smsp_dev_model_i.dev_rxq.pop_front(), (i == 1) ? 8'h69 : 8'hC3);
    end
    cfg_simplex = 1'b0;
    // Polarity first, so the hand-over of the clock line makes no false edge
    cfg_cpol = 1'b1;
    repeat (3) @(negedge clk);
    cfg_role_slave = 1'b1;
    cfg_cpha       = 1'b0;
    dev_master     = 1'b1;
    repeat (4) @(negedge clk);
    check({6'h0, sck_oe, mosi_oe}, 8'h00);
    check({7'h0, ss_n_o}, 8'h01);
    // Device clocks three bytes; host answers fill for two, as the byte queued after the first only loads when the second ends
    for (i = 1; i < 4; i++) begin
      smsp_dev_model_i.xfer(8'(i * 8'h11));
      if (i == 1) push(8'h96);
    end
    wait_done(3);
    for (i = 1; i < 4; i++) begin
      check(rxq.pop_front(), 8'(i * 8'h11));
      check(smsp_dev_model_i.dev_rxq.pop_front(), (i == 3) ? 8'h96 : `SMSP_FILL_BYTE);
    end
    finish_test();
  end

endmodule : smsp_host_tb_top

`default_nettype wire
